// file: common/host_interface_select_map.svh
// constants for the host interface select block
`ifndef HOST_INTERFACE_SELECT_MAP_SVH
`define HOST_INTERFACE_SELECT_MAP_SVH
`define HIS_SYS_CLK_KHZ 125000
`define HIS_STRAP_SETTLE_NS 32
`define HIS_STRAP_SETTLE_CYCLES (((`HIS_STRAP_SETTLE_NS) * (`HIS_SYS_CLK_KHZ) + 999999) / 1000000)
`define HIS_CNT_W 4
`define HIS_SEL_UART_TWI 1'b1
`define HIS_SAFE_BOOT_ON 1'b0
`define HIS_LINE_IDLE 1'b1
`define HIS_UART_SH_IDLE 10'h3FF
`define HIS_SPI_FILL 8'hFF
`define HIS_TWI_ADDR_DEFAULT 7'h42
`define HIS_BAUD_DIV_W 16
`endif

// file: common/host_interface_select_pkg.sv
// types for the host interface select block
package host_interface_select_pkg;
    typedef enum logic [1:0] {
        MODE_UART_TWI = 2'b01,
        MODE_SPI = 2'b10
    } host_mode_t;
    typedef enum logic [1:0] {
        BOOT_SETTLE = 2'b01,
        BOOT_RUN = 2'b10
    } boot_state_t;
    typedef enum logic [6:0] {
        TW_IDLE = 7'h01,
        TW_ADDR = 7'h02,
        TW_AACK = 7'h04,
        TW_WR = 7'h08,
        TW_WACK = 7'h10,
        TW_RD = 7'h20,
        TW_RACK = 7'h40
    } twi_state_t;
    typedef struct packed {
        logic clk;
        logic cs_n;
        logic [3:0] dout;
        logic [3:0] oe_n;
    } qflash_t;
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } byte_beat_t;
endpackage

// file: hw/host_interface_select.sv
// host port selection, strap capture and serial slave front ends
`timescale 1ns/1ps
`include "host_interface_select_map.svh"
// Function
// R1 - select high or open: uart and two-wire
// R2 - select low: spi slave port
// R3 - tx/miso, rx/mosi, scl/sck, sda/cs_n mapping
// R4 - spi mode: no two-wire port
// R5 - spi slave only, never drives sck/cs
// R6 - host keeps sck at or below maximum
// R7 - two-wire port is slave, i2c framing
// R8 - host keeps scl at or below maximum
// R9 - safe boot strap low: no positioning
// R10 - reset pin clears system and rtc
// R11 - keep uart and safe boot reachable
// R12 - uart baud rate is configurable
// R13 - quad flash port to optional flash
// R14 - straps latched once after reset release
module host_interface_select
    import host_interface_select_pkg::*;
#(
    parameter int FIFO_DEPTH = 8,
    parameter logic [6:0] TWI_ADDR = `HIS_TWI_ADDR_DEFAULT
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic general_io_ten,
    input wire logic safe_boot_strap_n,
    output logic pin_j5_out,
    output logic pin_j5_oe_n,
    input wire logic pin_j4_in,
    input wire logic pin_b1_in,
    input wire logic pin_a2_in,
    output logic pin_a2_out,
    output logic pin_a2_oe_n,
    input wire logic [`HIS_BAUD_DIV_W-1:0] baud_div,
    input wire logic tx_to_twi,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic rx_dropped,
    output host_mode_t host_mode,
    output logic straps_valid,
    output logic safe_boot_active,
    output logic nav_enable,
    output logic rtc_clear,
    input qflash_t qf_req,
    output qflash_t qf_pins,
    input wire logic [3:0] qf_din_pin,
    output logic [3:0] qf_din
);
    localparam int NS = 9;
    localparam logic [3:0] SETTLE = 4'(`HIS_STRAP_SETTLE_CYCLES);

    // synchronisers: sel, safe, j4, b1, a2, flash data
    logic [NS-1:0] meta_r, sync_r, prev_r, raw;
    assign raw = {qf_din_pin, pin_a2_in, pin_b1_in, pin_j4_in, safe_boot_strap_n, general_io_ten};
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            meta_r <= {NS{1'b1}};
            sync_r <= {NS{1'b1}};
            prev_r <= {NS{1'b1}};
        end else begin
            meta_r <= raw;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end
    logic rxd, lk, lk_prev, ld, ld_prev;
    assign rxd = sync_r[2];
    assign lk = sync_r[3];
    assign lk_prev = prev_r[3];
    assign ld = sync_r[4];
    assign ld_prev = prev_r[4];

    // startup: straps captured once, later pin changes ignored
    boot_state_t boot_r, boot_nxt;
    host_mode_t mode_r, mode_nxt;
    logic safe_r, safe_nxt, rtc_clear_r;
    logic [3:0] settle_r, settle_nxt;
    always_comb begin
        boot_nxt = boot_r;
        mode_nxt = mode_r;
        safe_nxt = safe_r;
        settle_nxt = settle_r;
        case (boot_r)
            BOOT_SETTLE: begin
                settle_nxt = settle_r + 4'h1;
                if (settle_r == SETTLE) begin
                    boot_nxt = BOOT_RUN; // R14
                    mode_nxt = (sync_r[0] == `HIS_SEL_UART_TWI) ? MODE_UART_TWI : MODE_SPI; // R1 R2
                    safe_nxt = (sync_r[1] == `HIS_SAFE_BOOT_ON); // R9
                end
            end
            BOOT_RUN: boot_nxt = BOOT_RUN;
            default: boot_nxt = BOOT_SETTLE;
        endcase
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            boot_r <= BOOT_SETTLE;
            mode_r <= MODE_UART_TWI;
            safe_r <= 1'b0;
            settle_r <= 4'h0;
            rtc_clear_r <= 1'b1; // R10
        end else begin
            boot_r <= boot_nxt;
            mode_r <= mode_nxt;
            safe_r <= safe_nxt;
            settle_r <= settle_nxt;
            rtc_clear_r <= 1'b0;
        end
    end
    logic run, uart_on, spi_on;
    assign run = (boot_r == BOOT_RUN);
    assign uart_on = run && (mode_r == MODE_UART_TWI);
    assign spi_on = run && (mode_r == MODE_SPI);
    assign host_mode = mode_r;
    assign straps_valid = run;
    assign safe_boot_active = safe_r;
    assign nav_enable = run && !safe_r; // R9
    assign rtc_clear = rtc_clear_r; // R10

    // shared transmit holding byte for spi and two-wire reads
    logic [7:0] hold_r, hold_nxt;
    logic hold_v_r, hold_v_nxt, spi_take, twi_take, tx_take, utx_busy_r;
    logic fifo_ready;
    assign tx_ready = run && ((uart_on && !tx_to_twi) ? !utx_busy_r : !hold_v_r);
    assign tx_take = tx_valid && tx_ready;
    always_comb begin
        hold_nxt = hold_r;
        hold_v_nxt = hold_v_r;
        if (spi_take || twi_take) begin
            hold_v_nxt = 1'b0;
        end
        if (tx_take && !(uart_on && !tx_to_twi)) begin
            hold_nxt = tx_data;
            hold_v_nxt = 1'b1;
        end
    end

    // uart receive and transmit, bit time = baud_div cycles
    logic urx_busy_r, urx_busy_nxt, urx_push, utx_busy_nxt;
    logic [`HIS_BAUD_DIV_W-1:0] urx_cnt_r, urx_cnt_nxt, utx_cnt_r, utx_cnt_nxt;
    logic [3:0] urx_bit_r, urx_bit_nxt, utx_bit_r, utx_bit_nxt;
    logic [7:0] urx_sh_r, urx_sh_nxt;
    logic [9:0] utx_sh_r, utx_sh_nxt;
    always_comb begin
        urx_busy_nxt = urx_busy_r;
        urx_cnt_nxt = urx_cnt_r;
        urx_bit_nxt = urx_bit_r;
        urx_sh_nxt = urx_sh_r;
        urx_push = 1'b0;
        if (!urx_busy_r) begin
            if (uart_on && !rxd) begin
                urx_busy_nxt = 1'b1;
                urx_cnt_nxt = baud_div >> 1; // R12
                urx_bit_nxt = 4'h0;
            end
        end else if (urx_cnt_r != '0) begin
            urx_cnt_nxt = urx_cnt_r - 1'b1;
        end else begin
            urx_cnt_nxt = baud_div - 1'b1; // R12
            urx_bit_nxt = urx_bit_r + 4'h1;
            if (urx_bit_r == 4'h0) begin
                urx_busy_nxt = !rxd; // glitch on start bit
            end else if (urx_bit_r <= 4'h8) begin
                urx_sh_nxt = {rxd, urx_sh_r[7:1]};
            end else begin
                urx_busy_nxt = 1'b0;
                urx_push = rxd; // framing error drops byte
            end
        end
        utx_busy_nxt = utx_busy_r;
        utx_cnt_nxt = utx_cnt_r;
        utx_bit_nxt = utx_bit_r;
        utx_sh_nxt = utx_sh_r;
        if (!utx_busy_r) begin
            if (tx_take && uart_on && !tx_to_twi) begin
                utx_busy_nxt = 1'b1;
                utx_sh_nxt = {1'b1, tx_data, 1'b0};
                utx_cnt_nxt = baud_div - 1'b1;
                utx_bit_nxt = 4'h0;
            end
        end else if (utx_cnt_r != '0) begin
            utx_cnt_nxt = utx_cnt_r - 1'b1;
        end else if (utx_bit_r == 4'h9) begin
            utx_busy_nxt = 1'b0;
        end else begin
            utx_sh_nxt = {1'b1, utx_sh_r[9:1]};
            utx_bit_nxt = utx_bit_r + 4'h1;
            utx_cnt_nxt = baud_div - 1'b1;
        end
    end

    // spi slave mode 0; sck and cs_n only sampled, never driven
    logic spi_cs, spi_cs_prev, spi_rise, spi_fall, spi_push;
    logic [2:0] spi_cnt_r, spi_cnt_nxt;
    logic [7:0] spi_rx_r, spi_rx_nxt, spi_tx_r, spi_tx_nxt;
    assign spi_cs = spi_on && !ld; // R5
    assign spi_cs_prev = spi_on && !ld_prev;
    assign spi_rise = spi_cs && lk && !lk_prev; // R6
    assign spi_fall = spi_cs && !lk && lk_prev;
    always_comb begin
        spi_cnt_nxt = spi_cnt_r;
        spi_rx_nxt = spi_rx_r;
        spi_tx_nxt = spi_tx_r;
        spi_push = 1'b0;
        spi_take = 1'b0;
        if (!spi_cs) begin
            spi_cnt_nxt = 3'h0;
        end else if (!spi_cs_prev || (spi_rise && spi_cnt_r == 3'h7)) begin
            spi_tx_nxt = hold_v_r ? hold_r : `HIS_SPI_FILL;
            spi_take = hold_v_r;
        end else if (spi_fall && spi_cnt_r != 3'h0) begin
            spi_tx_nxt = {spi_tx_r[6:0], 1'b1};
        end
        if (spi_rise) begin
            spi_rx_nxt = {spi_rx_r[6:0], rxd};
            spi_cnt_nxt = spi_cnt_r + 3'h1;
            spi_push = (spi_cnt_r == 3'h7);
        end
    end

    // two-wire slave: start, stop, address match, ack and read back
    twi_state_t tw_r, tw_nxt;
    logic [3:0] tw_cnt_r, tw_cnt_nxt;
    logic [7:0] tw_sh_r, tw_sh_nxt;
    logic tw_low_r, tw_low_nxt, tw_ok_r, tw_ok_nxt, twi_push;
    logic tw_start, tw_stop, tw_rise, tw_fall, tw_on;
    assign tw_on = uart_on; // R4
    assign tw_start = tw_on && lk && lk_prev && ld_prev && !ld; // R7
    assign tw_stop = tw_on && lk && lk_prev && !ld_prev && ld;
    assign tw_rise = tw_on && lk && !lk_prev; // R8
    assign tw_fall = tw_on && !lk && lk_prev;
    always_comb begin
        tw_nxt = tw_r;
        tw_cnt_nxt = tw_cnt_r;
        tw_sh_nxt = tw_sh_r;
        tw_low_nxt = tw_low_r;
        tw_ok_nxt = tw_ok_r;
        twi_push = 1'b0;
        twi_take = 1'b0;
        case (tw_r)
            TW_IDLE: tw_low_nxt = 1'b0;
            TW_ADDR, TW_WR: begin
                if (tw_rise && tw_cnt_r != 4'h8) begin
                    tw_sh_nxt = {tw_sh_r[6:0], ld};
                    tw_cnt_nxt = tw_cnt_r + 4'h1;
                end else if (tw_fall && tw_cnt_r == 4'h8) begin
                    tw_cnt_nxt = 4'h0;
                    if (tw_r == TW_ADDR) begin
                        tw_ok_nxt = (tw_sh_r[7:1] == TWI_ADDR);
                        tw_low_nxt = tw_ok_nxt;
                        tw_nxt = tw_ok_nxt ? TW_AACK : TW_IDLE;
                    end else begin
                        // full fifo or busy uart push means not acknowledged
                        tw_ok_nxt = fifo_ready && !urx_push;
                        twi_push = tw_ok_nxt;
                        tw_low_nxt = tw_ok_nxt;
                        tw_nxt = TW_WACK;
                    end
                end
            end
            TW_AACK: begin
                if (tw_fall) begin
                    if (tw_sh_r[0]) begin
                        tw_nxt = TW_RD;
                        tw_sh_nxt = hold_v_r ? hold_r : `HIS_SPI_FILL;
                        twi_take = hold_v_r;
                        tw_low_nxt = hold_v_r ? !hold_r[7] : 1'b0;
                    end else begin
                        tw_nxt = TW_WR;
                        tw_low_nxt = 1'b0;
                    end
                end
            end
            TW_WACK: begin
                if (tw_fall) begin
                    tw_low_nxt = 1'b0;
                    tw_nxt = tw_ok_r ? TW_WR : TW_IDLE;
                end
            end
            TW_RD: begin
                if (tw_fall) begin
                    if (tw_cnt_r == 4'h7) begin
                        tw_nxt = TW_RACK;
                        tw_low_nxt = 1'b0;
                    end else begin
                        tw_sh_nxt = {tw_sh_r[6:0], 1'b1};
                        tw_low_nxt = !tw_sh_r[6];
                        tw_cnt_nxt = tw_cnt_r + 4'h1;
                    end
                end
            end
            TW_RACK: begin
                if (tw_rise) begin
                    tw_ok_nxt = !ld;
                end else if (tw_fall) begin
                    tw_cnt_nxt = 4'h0;
                    if (tw_ok_r) begin
                        tw_nxt = TW_RD;
                        tw_sh_nxt = hold_v_r ? hold_r : `HIS_SPI_FILL;
                        twi_take = hold_v_r;
                        tw_low_nxt = hold_v_r ? !hold_r[7] : 1'b0;
                    end else begin
                        tw_nxt = TW_IDLE;
                    end
                end
            end
            default: tw_nxt = TW_IDLE;
        endcase
        if (tw_start) begin
            tw_nxt = TW_ADDR; // repeated start too
            tw_cnt_nxt = 4'h0;
            tw_low_nxt = 1'b0;
        end else if (tw_stop || !tw_on) begin
            tw_nxt = TW_IDLE;
            tw_low_nxt = 1'b0;
        end
    end

    // all front ends register here
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            hold_r <= 8'h00;
            hold_v_r <= 1'b0;
            urx_busy_r <= 1'b0;
            urx_cnt_r <= '0;
            urx_bit_r <= 4'h0;
            urx_sh_r <= 8'h00;
            utx_busy_r <= 1'b0;
            utx_cnt_r <= '0;
            utx_bit_r <= 4'h0;
            utx_sh_r <= `HIS_UART_SH_IDLE;
            spi_cnt_r <= 3'h0;
            spi_rx_r <= 8'h00;
            spi_tx_r <= `HIS_SPI_FILL;
            tw_r <= TW_IDLE;
            tw_cnt_r <= 4'h0;
            tw_sh_r <= 8'h00;
            tw_low_r <= 1'b0;
            tw_ok_r <= 1'b0;
        end else begin
            hold_r <= hold_nxt;
            hold_v_r <= hold_v_nxt;
            urx_busy_r <= urx_busy_nxt;
            urx_cnt_r <= urx_cnt_nxt;
            urx_bit_r <= urx_bit_nxt;
            urx_sh_r <= urx_sh_nxt;
            utx_busy_r <= utx_busy_nxt;
            utx_cnt_r <= utx_cnt_nxt;
            utx_bit_r <= utx_bit_nxt;
            utx_sh_r <= utx_sh_nxt;
            spi_cnt_r <= spi_cnt_nxt;
            spi_rx_r <= spi_rx_nxt;
            spi_tx_r <= spi_tx_nxt;
            tw_r <= tw_nxt;
            tw_cnt_r <= tw_cnt_nxt;
            tw_sh_r <= tw_sh_nxt;
            tw_low_r <= tw_low_nxt;
            tw_ok_r <= tw_ok_nxt;
        end
    end

    // shared pins; outputs released until straps are in
    always_comb begin
        pin_j5_out = `HIS_LINE_IDLE;
        pin_j5_oe_n = 1'b1;
        pin_a2_out = 1'b0;
        pin_a2_oe_n = 1'b1; // R4 R5
        if (uart_on) begin
            pin_j5_out = utx_sh_r[0]; // R3 R11
            pin_j5_oe_n = 1'b0;
            pin_a2_oe_n = !tw_low_r; // R7
        end else if (spi_on) begin
            pin_j5_out = spi_tx_r[7]; // R3
            pin_j5_oe_n = !spi_cs;
        end
    end

    // serial bytes cannot be stalled, so uart and spi drop on full
    byte_beat_t push;
    always_comb begin
        push.valid = urx_push || spi_push || twi_push;
        push.data = urx_push ? urx_sh_r : (spi_push ? {spi_rx_r[6:0], rxd} : tw_sh_r);
    end
    assign rx_dropped = (urx_push || spi_push) && !fifo_ready;

    word_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) rx_fifo (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .in_valid(push.valid),
        .in_ready(fifo_ready),
        .in_data(push.data),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_data)
    );

    // quad flash port registered out and in
    qflash_t qf_r;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            qf_r <= '{clk: 1'b0, cs_n: 1'b1, dout: 4'h0, oe_n: 4'hF};
        end else begin
            qf_r <= qf_req; // R13
        end
    end
    assign qf_pins = qf_r;
    assign qf_din = sync_r[8:5];
endmodule

// file: hw/word_fifo.sv
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic full, empty, do_wr, do_rd;

    // extra pointer bit tells full from empty
    assign full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
    assign empty = (wr_r == rd_r);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_r[AW-1:0]];
    assign do_wr = in_valid && !full;
    assign do_rd = out_ready && !empty;

    always_comb begin
        wr_nxt = do_wr ? wr_r + 1'b1 : wr_r;
        rd_nxt = do_rd ? rd_r + 1'b1 : rd_r;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (do_wr) begin
            mem[wr_r[AW-1:0]] <= in_data;
        end
    end
endmodule

// file: tb/host_interface_select_assertions.sv
// concurrent checks on the host interface select ports
`timescale 1ns/1ps
module host_interface_select_checker
    import host_interface_select_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic pin_j5_out,
    input wire logic pin_a2_oe_n,
    input wire logic tx_ready,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic rx_dropped,
    input wire host_mode_t host_mode,
    input wire logic straps_valid,
    input wire logic safe_boot_active,
    input wire logic nav_enable,
    input wire logic rtc_clear
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    a_spi_no_sda: assert property (
        host_mode == MODE_SPI |-> pin_a2_oe_n) else $error("sda driven in spi mode");
    // straps pass a synchroniser and settle count first
    a_strap_settle: assert property (
        !$past(nrst) |-> !straps_valid ##[1:12] straps_valid) else $error("straps late");
    a_strap_hold: assert property (
        straps_valid && $past(straps_valid) |-> $stable(host_mode) && $stable(safe_boot_active))
        else $error("strap result moved");
    a_uart_idle: assert property (
        host_mode == MODE_UART_TWI && straps_valid && tx_ready |-> pin_j5_out)
        else $error("uart tx not idle high");
    a_nav_cause: assert property (
        nav_enable |-> straps_valid && !safe_boot_active) else $error("nav in safe boot");
    a_nav_run: assert property (
        straps_valid && !safe_boot_active |-> ##[0:1] nav_enable) else $error("nav missing");
    a_rtc_release: assert property (
        rtc_clear |=> !rtc_clear) else $error("rtc clear held after reset");
    a_tx_gate: assert property (
        !straps_valid |-> !tx_ready) else $error("tx ready before straps");
    a_rx_hold: assert property (
        rx_valid && !rx_ready |=> rx_valid && $stable(rx_data)) else $error("rx data moved");
    a_drop_pulse: assert property (
        rx_dropped |=> !rx_dropped) else $error("drop pulse too long");
endmodule
bind host_interface_select host_interface_select_checker chk_i (
    .sys_clk(sys_clk), .nrst(nrst), .pin_j5_out(pin_j5_out), .pin_a2_oe_n(pin_a2_oe_n),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_dropped(rx_dropped), .host_mode(host_mode), .straps_valid(straps_valid),
    .safe_boot_active(safe_boot_active), .nav_enable(nav_enable), .rtc_clear(rtc_clear)
);

// file: tb/host_interface_select_tb.sv
// self-checking bench for host interface select
`timescale 1ns/1ps
module host_interface_select_tb
    import host_interface_select_pkg::*;
;
    typedef struct packed {
        logic sel;
        logic safe;
        logic [15:0] baud;
        logic [7:0] data;
        host_mode_t mode;
    } row_t;
    row_t rows [4] = '{
        '{1'b1, 1'b1, 16'h0008, 8'h3C, MODE_UART_TWI},
        '{1'b1, 1'b0, 16'h000D, 8'hA7, MODE_UART_TWI},
        '{1'b0, 1'b1, 16'h0008, 8'h5A, MODE_SPI},
        '{1'b0, 1'b0, 16'h0008, 8'hC3, MODE_SPI}
    };
    logic sys_clk, nrst, general_io_ten, safe_boot_strap_n, pin_j4_in, pin_b1_in, pin_a2_in;
    logic pin_j5_out, pin_j5_oe_n, pin_a2_out, pin_a2_oe_n, tx_ready, rx_valid, rx_dropped;
    logic straps_valid, safe_boot_active, nav_enable, rtc_clear, tx_valid, rx_ready, host_sel;
    logic j5_w;
    logic [15:0] baud_div;
    logic [7:0] tx_data, rx_data, got;
    host_mode_t host_mode;
    qflash_t qf_pins;
    logic [3:0] qf_din;
    int failures = 0;
    int checks = 0;
    int cycles = 0;
    int drops = 0;
    // open-drain sda with pull-up; released j5 reads high like an idle uart line
    assign pin_a2_in = (!pin_a2_oe_n && !pin_a2_out) ? 1'b0 : host_sel;
    assign j5_w = pin_j5_oe_n ? 1'b1 : pin_j5_out;
    host_link_model host (
        .rx_line(pin_j4_in), .clk_line(pin_b1_in), .sel_line(host_sel), .tx_line(j5_w)
    );
    host_interface_select uut (
        .sys_clk(sys_clk), .nrst(nrst), .general_io_ten(general_io_ten),
        .safe_boot_strap_n(safe_boot_strap_n), .pin_j5_out(pin_j5_out),
        .pin_j5_oe_n(pin_j5_oe_n), .pin_j4_in(pin_j4_in), .pin_b1_in(pin_b1_in),
        .pin_a2_in(pin_a2_in), .pin_a2_out(pin_a2_out), .pin_a2_oe_n(pin_a2_oe_n),
        .baud_div(baud_div), .tx_to_twi(1'b0), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_dropped(rx_dropped), .host_mode(host_mode), .straps_valid(straps_valid),
        .safe_boot_active(safe_boot_active), .nav_enable(nav_enable), .rtc_clear(rtc_clear),
        .qf_req({1'b1, 1'b0, 4'h6, 4'h9}), .qf_pins(qf_pins), .qf_din_pin(4'h5),
        .qf_din(qf_din)
    );
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task finish_test;
        $display("failures=%0d checks=%0d", failures, checks);
        if (failures == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // hang guard, about twice what the run needs
    always @(posedge sys_clk) begin
        cycles++;
        if (rx_dropped === 1'b1)
            drops++;
        if (cycles == 60000) begin
            failures++;
            finish_test();
        end
    end
    task chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
            failures++;
        end
    endtask
    task push(input logic [7:0] b);
        int n;
        n = 0;
        @(negedge sys_clk);
        tx_data = b;
        tx_valid = 1'b1;
        while (tx_ready !== 1'b1 && n < 4000) begin
            @(negedge sys_clk);
            n++;
        end
        @(negedge sys_clk);
        tx_valid = 1'b0;
    endtask
    task pop(input logic [7:0] e);
        int n;
        n = 0;
        @(negedge sys_clk);
        while (rx_valid !== 1'b1 && n < 4000) begin
            @(negedge sys_clk);
            n++;
        end
        chk(rx_data, e);
        rx_ready = 1'b1;
        @(negedge sys_clk);
        rx_ready = 1'b0;
    endtask
    // straps must already be steady when this is entered
    task do_reset;
        @(negedge sys_clk);
        nrst = 1'b0;
        repeat (12) @(negedge sys_clk);
        chk(8'(rtc_clear), 8'h01);
        chk(8'(straps_valid), 8'h00);
        nrst = 1'b1;
        repeat (12) @(negedge sys_clk);
        chk(8'(rtc_clear), 8'h00);
        chk(8'(straps_valid), 8'h01);
    endtask
    initial begin
        nrst = 1'b0;
        general_io_ten = 1'b1;
        safe_boot_strap_n = 1'b1;
        baud_div = 16'h0008;
        tx_data = 8'h00;
        tx_valid = 1'b0;
        rx_ready = 1'b0;
        foreach (rows[k]) begin
            general_io_ten = rows[k].sel;
            safe_boot_strap_n = rows[k].safe;
            baud_div = rows[k].baud;
            host.bit_ns = 8 * int'(rows[k].baud);
            do_reset();
            chk(8'(host_mode), 8'(rows[k].mode));
            chk(8'(safe_boot_active), 8'(!rows[k].safe));
            chk(8'(nav_enable), 8'(rows[k].safe));
            if (rows[k].mode == MODE_UART_TWI) begin
                fork
                    host.uart_recv(got);
                    push(rows[k].data);
                join
                chk(got, rows[k].data);
                host.uart_send(~rows[k].data);
                pop(~rows[k].data);
            end else begin
                push(rows[k].data);
                host.spi_xfer(~rows[k].data, got);
                chk(got, rows[k].data);
                pop(~rows[k].data);
                host.spi_xfer(8'h00, got);
                chk(got, 8'hFF);
                pop(8'h00);
                chk(8'(pin_a2_oe_n), 8'h01);
            end
        end
        general_io_ten = 1'b1;
        safe_boot_strap_n = 1'b1;
        baud_div = 16'h0008;
        host.bit_ns = 64;
        do_reset();
        // late strap moves must not reach the latched mode
        general_io_ten = 1'b0;
        safe_boot_strap_n = 1'b0;
        repeat (20) @(negedge sys_clk);
        chk(8'(host_mode), 8'(MODE_UART_TWI));
        chk(8'(nav_enable), 8'h01);
        chk({qf_pins.clk, qf_pins.cs_n, 2'b00, qf_din}, 8'h85);
        chk({qf_pins.dout, qf_pins.oe_n}, 8'h69);
        drops = 0;
        for (int k = 0; k < 9; k++)
            host.uart_send(8'h10 + 8'(k));
        repeat (40) @(negedge sys_clk);
        chk(8'(drops), 8'h01);
        for (int k = 0; k < 8; k++)
            pop(8'h10 + 8'(k));
        host.twi_write(8'h84, 8'h6E);
        pop(8'h6E);
        repeat (4) @(negedge sys_clk);
        chk(8'(rx_valid), 8'h00);
        do_reset();
        chk(8'(host_mode), 8'(MODE_SPI));
        chk(8'(nav_enable), 8'h00);
        finish_test();
    end
endmodule

// file: tb/host_link_model.sv
// host cpu model driving the shared serial pins
`timescale 1ns/1ps
module host_link_model #(
    parameter int SCK_HALF_NS = 168,
    parameter int TWI_HALF_NS = 5056
) (
    output logic rx_line,
    output logic clk_line,
    output logic sel_line,
    input wire logic tx_line
);
    int bit_ns = 64;
    initial begin
        rx_line = 1'b1;
        clk_line = 1'b0;
        sel_line = 1'b1;
    end
    // lsb first, one idle bit first in case spi left the line low
    task uart_send(input logic [7:0] b);
        rx_line = 1'b1;
        #(bit_ns);
        rx_line = 1'b0;
        #(bit_ns);
        for (int i = 0; i < 8; i++) begin
            rx_line = b[i];
            #(bit_ns);
        end
        rx_line = 1'b1;
        #(bit_ns);
    endtask
    // samples mid-bit after the falling start edge
    task uart_recv(output logic [7:0] b);
        int n;
        n = 0;
        while (tx_line !== 1'b0 && n < 100000) begin
            #1;
            n++;
        end
        #(bit_ns + bit_ns / 2);
        for (int i = 0; i < 8; i++) begin
            b[i] = tx_line;
            #(bit_ns);
        end
    endtask
    // mode 0, msb first; clock stands low outside frames
    task spi_xfer(input logic [7:0] m, output logic [7:0] s);
        sel_line = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            rx_line = m[i];
            #(SCK_HALF_NS);
            clk_line = 1'b1;
            s[i] = tx_line;
            #(SCK_HALF_NS);
            clk_line = 1'b0;
        end
        #(SCK_HALF_NS);
        sel_line = 1'b1;
        rx_line = ~m[0];
    endtask
    // start, address, data, stop; acks come from the device pulling sda
    task twi_write(input logic [7:0] a, input logic [7:0] d);
        logic [18:0] f;
        f = {a, 1'b1, d, 1'b1, 1'b0};
        clk_line = 1'b1;
        #(TWI_HALF_NS);
        sel_line = 1'b0;
        for (int i = 18; i >= 0; i--) begin
            #(TWI_HALF_NS);
            clk_line = 1'b0;
            #(TWI_HALF_NS / 2);
            sel_line = f[i];
            #(TWI_HALF_NS / 2);
            clk_line = 1'b1;
        end
        #(TWI_HALF_NS);
        sel_line = 1'b1;
        #(TWI_HALF_NS);
        clk_line = 1'b0;
    endtask
endmodule
